/* hdl/cuis_pkg.sv */
// Constants shared by the capture unit input select block
package cuis_pkg;

  // ----------------------------------------
  // Register bus geometry
  // ----------------------------------------
  localparam int CUIS_ADDR_W = 8;
  localparam int CUIS_DATA_W = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CUIS_OFS_CAPTURE_TRAP_SEL = 8'h00;
  localparam logic [7:0] CUIS_OFS_POSITION_RUN_SEL = 8'h01;
  localparam logic [7:0] CUIS_OFS_SECOND_TIMER_SEL = 8'h02;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CUIS_RST_CAPTURE_TRAP_SEL = 8'h00;
  localparam logic [7:0] CUIS_RST_POSITION_RUN_SEL = 8'h00;
  localparam logic [1:0] CUIS_RST_SECOND_TIMER_SEL = 2'h0;
  localparam logic [7:0] CUIS_RST_RDATA = 8'h00;

  // ----------------------------------------
  // Field positions (low bit of each two-bit field)
  // ----------------------------------------
  localparam int CUIS_POS_CHAN0 = 0;
  localparam int CUIS_POS_CHAN1 = 2;
  localparam int CUIS_POS_CHAN2 = 4;
  localparam int CUIS_POS_TRAP = 6;
  localparam int CUIS_POS_HALL0 = 0;
  localparam int CUIS_POS_HALL1 = 2;
  localparam int CUIS_POS_HALL2 = 4;
  localparam int CUIS_POS_TIMER_A = 6;
  localparam int CUIS_POS_TIMER_B = 0;
  localparam int CUIS_FIELD_W = 2;

  // ----------------------------------------
  // Module input indices and legal code masks (bit n set: code n routes pin n)
  // ----------------------------------------
  localparam int CUIS_NUM_IN = 9;
  localparam int CUIS_IDX_CHAN0 = 0;
  localparam int CUIS_IDX_CHAN1 = 1;
  localparam int CUIS_IDX_CHAN2 = 2;
  localparam int CUIS_IDX_TRAP = 3;
  localparam int CUIS_IDX_HALL0 = 4;
  localparam int CUIS_IDX_HALL1 = 5;
  localparam int CUIS_IDX_HALL2 = 6;
  localparam int CUIS_IDX_TIMER_A = 7;
  localparam int CUIS_IDX_TIMER_B = 8;
  // Packed as input 8 down to input 0, four bits each
  localparam logic [35:0] CUIS_VALID_MASKS = {4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'hB, 4'hF, 4'h9};

endpackage : cuis_pkg

/* hdl/cuis_mux4.sv */
// Four-way source pin selector with a defined level on reserved codes
`timescale 1ns/1ns
module cuis_mux4 #(
  parameter logic [3:0] VALID_MASK = 4'hF,
  parameter logic INACTIVE_LEVEL = 1'b0
) (
  input wire logic [3:0] i_src,
  input wire logic [1:0] i_code,
  output logic o_sel
);

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  // Reserved codes park the input instead of passing a floating pin
  always_comb
  begin
    o_sel = INACTIVE_LEVEL; // RULE_10
    if (VALID_MASK[i_code])
    begin
      o_sel = i_src[i_code];
    end
  end

endmodule // cuis_mux4

/* hdl/cuis_top.sv */
// Top of the capture unit input select block: select registers and input routing
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns

// Function
// RULE_01 - Channel 0 capture: code 00 pin0, 11 pin3
// RULE_02 - Channel 1 capture: codes select pins 0-3
// RULE_03 - Channel 2 capture: pins 0,1,3; 10 reserved
// RULE_04 - Trap input: pins 0,1,2; 11 reserved
// RULE_05 - Three hall inputs: pins 0-2; 11 reserved
// RULE_06 - Timer A run input: pins 0-2
// RULE_07 - Timer B run input: pins 0-2; 11 reserved
// RULE_08 - Third register upper bits read zero
// RULE_09 - Selects route inputs only, never outputs
// RULE_10 - Reserved codes give defined inactive level
module cuis_top #(
  parameter logic INACTIVE_LEVEL = 1'b0
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic [3:0] I_CHAN0_CAPTURE_SRC,
  input wire logic [3:0] I_CHAN1_CAPTURE_SRC,
  input wire logic [3:0] I_CHAN2_CAPTURE_SRC,
  input wire logic [3:0] I_TRAP_SRC,
  input wire logic [3:0] I_HALL_POS0_SRC,
  input wire logic [3:0] I_HALL_POS1_SRC,
  input wire logic [3:0] I_HALL_POS2_SRC,
  input wire logic [3:0] I_TIMER_A_HW_RUN_SRC,
  input wire logic [3:0] I_TIMER_B_HW_RUN_SRC,
  output logic O_CHAN0_CAPTURE_IN,
  output logic O_CHAN1_CAPTURE_IN,
  output logic O_CHAN2_CAPTURE_IN,
  output logic O_TRAP_IN,
  output logic O_HALL_POS0_IN,
  output logic O_HALL_POS1_IN,
  output logic O_HALL_POS2_IN,
  output logic O_TIMER_A_HW_RUN_IN,
  output logic O_TIMER_B_HW_RUN_IN
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] capture_trap_input_select; // Channel and trap fields
  logic [7:0] position_run_input_select; // Hall and timer A fields
  logic [1:0] second_timer_run_input_select; // Only the stored bits of the third register
  logic [7:0] next_capture_trap_input_select;
  logic [7:0] next_position_run_input_select;
  logic [1:0] next_second_timer_run_input_select;
  logic [7:0] next_rdata;

  // Register writes; an unmapped address writes nothing
  always_comb
  begin
    next_capture_trap_input_select = capture_trap_input_select;
    next_position_run_input_select = position_run_input_select;
    next_second_timer_run_input_select = second_timer_run_input_select;
    if (I_WR)
    begin
      if (I_ADDR == cuis_pkg::CUIS_OFS_CAPTURE_TRAP_SEL)
      begin
        next_capture_trap_input_select = I_WDATA;
      end
      else if (I_ADDR == cuis_pkg::CUIS_OFS_POSITION_RUN_SEL)
      begin
        next_position_run_input_select = I_WDATA;
      end
      else if (I_ADDR == cuis_pkg::CUIS_OFS_SECOND_TIMER_SEL)
      begin
        // Upper bits are not stored, so a careless write cannot leak into a read
        next_second_timer_run_input_select = I_WDATA[1:0]; // RULE_08
      end
    end
  end

  // Read path; data stands only in the cycle after the strobe
  always_comb
  begin
    next_rdata = cuis_pkg::CUIS_RST_RDATA;
    if (I_RD)
    begin
      if (I_ADDR == cuis_pkg::CUIS_OFS_CAPTURE_TRAP_SEL)
      begin
        next_rdata = capture_trap_input_select;
      end
      else if (I_ADDR == cuis_pkg::CUIS_OFS_POSITION_RUN_SEL)
      begin
        next_rdata = position_run_input_select;
      end
      else if (I_ADDR == cuis_pkg::CUIS_OFS_SECOND_TIMER_SEL)
      begin
        next_rdata = {6'h00, second_timer_run_input_select}; // RULE_08
      end
    end
  end

  // Register stage for the register file and read data
  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      capture_trap_input_select <= cuis_pkg::CUIS_RST_CAPTURE_TRAP_SEL;
      position_run_input_select <= cuis_pkg::CUIS_RST_POSITION_RUN_SEL;
      second_timer_run_input_select <= cuis_pkg::CUIS_RST_SECOND_TIMER_SEL;
      O_RDATA <= cuis_pkg::CUIS_RST_RDATA;
    end
    else
    begin
      capture_trap_input_select <= next_capture_trap_input_select;
      position_run_input_select <= next_position_run_input_select;
      second_timer_run_input_select <= next_second_timer_run_input_select;
      O_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Input routing
  // ----------------------------------------
  // Only input paths live here; pin output direction belongs to the port logic
  logic [3:0] src [cuis_pkg::CUIS_NUM_IN]; // Candidate pins per module input
  logic [1:0] code [cuis_pkg::CUIS_NUM_IN]; // Selected code per module input
  logic [cuis_pkg::CUIS_NUM_IN-1:0] routed; // Mux results before the output stage
  logic [cuis_pkg::CUIS_NUM_IN-1:0] routed_q; // Registered module inputs

  assign src[cuis_pkg::CUIS_IDX_CHAN0] = I_CHAN0_CAPTURE_SRC;
  assign src[cuis_pkg::CUIS_IDX_CHAN1] = I_CHAN1_CAPTURE_SRC;
  assign src[cuis_pkg::CUIS_IDX_CHAN2] = I_CHAN2_CAPTURE_SRC;
  assign src[cuis_pkg::CUIS_IDX_TRAP] = I_TRAP_SRC;
  assign src[cuis_pkg::CUIS_IDX_HALL0] = I_HALL_POS0_SRC;
  assign src[cuis_pkg::CUIS_IDX_HALL1] = I_HALL_POS1_SRC;
  assign src[cuis_pkg::CUIS_IDX_HALL2] = I_HALL_POS2_SRC;
  assign src[cuis_pkg::CUIS_IDX_TIMER_A] = I_TIMER_A_HW_RUN_SRC;
  assign src[cuis_pkg::CUIS_IDX_TIMER_B] = I_TIMER_B_HW_RUN_SRC;

  // Field extraction from the three select registers
  assign code[cuis_pkg::CUIS_IDX_CHAN0] = capture_trap_input_select[cuis_pkg::CUIS_POS_CHAN0 +: 2]; // RULE_01
  assign code[cuis_pkg::CUIS_IDX_CHAN1] = capture_trap_input_select[cuis_pkg::CUIS_POS_CHAN1 +: 2]; // RULE_02
  assign code[cuis_pkg::CUIS_IDX_CHAN2] = capture_trap_input_select[cuis_pkg::CUIS_POS_CHAN2 +: 2]; // RULE_03
  assign code[cuis_pkg::CUIS_IDX_TRAP] = capture_trap_input_select[cuis_pkg::CUIS_POS_TRAP +: 2]; // RULE_04
  assign code[cuis_pkg::CUIS_IDX_HALL0] = position_run_input_select[cuis_pkg::CUIS_POS_HALL0 +: 2]; // RULE_05
  assign code[cuis_pkg::CUIS_IDX_HALL1] = position_run_input_select[cuis_pkg::CUIS_POS_HALL1 +: 2]; // RULE_05
  assign code[cuis_pkg::CUIS_IDX_HALL2] = position_run_input_select[cuis_pkg::CUIS_POS_HALL2 +: 2]; // RULE_05
  assign code[cuis_pkg::CUIS_IDX_TIMER_A] = position_run_input_select[cuis_pkg::CUIS_POS_TIMER_A +: 2]; // RULE_06
  assign code[cuis_pkg::CUIS_IDX_TIMER_B] = second_timer_run_input_select; // RULE_07

  // One selector per module input, each with its own legal code set
  for (genvar g = 0; g < cuis_pkg::CUIS_NUM_IN; g++)
  begin : g_route
    cuis_mux4 #(
      .VALID_MASK(cuis_pkg::CUIS_VALID_MASKS[4*g +: 4]),
      .INACTIVE_LEVEL(INACTIVE_LEVEL)
    ) u_mux (
      .i_src(src[g]),
      .i_code(code[g]),
      .o_sel(routed[g])
    ); // RULE_09
  end

  // Output stage: one cycle of latency buys glitch-free outputs during a select change
  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      routed_q <= '0;
    end
    else
    begin
      routed_q <= routed;
    end
  end

  assign O_CHAN0_CAPTURE_IN = routed_q[cuis_pkg::CUIS_IDX_CHAN0];
  assign O_CHAN1_CAPTURE_IN = routed_q[cuis_pkg::CUIS_IDX_CHAN1];
  assign O_CHAN2_CAPTURE_IN = routed_q[cuis_pkg::CUIS_IDX_CHAN2];
  assign O_TRAP_IN = routed_q[cuis_pkg::CUIS_IDX_TRAP];
  assign O_HALL_POS0_IN = routed_q[cuis_pkg::CUIS_IDX_HALL0];
  assign O_HALL_POS1_IN = routed_q[cuis_pkg::CUIS_IDX_HALL1];
  assign O_HALL_POS2_IN = routed_q[cuis_pkg::CUIS_IDX_HALL2];
  assign O_TIMER_A_HW_RUN_IN = routed_q[cuis_pkg::CUIS_IDX_TIMER_A];
  assign O_TIMER_B_HW_RUN_IN = routed_q[cuis_pkg::CUIS_IDX_TIMER_B];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  chk_chan0_pin3: assert property ( // RULE_01
    capture_trap_input_select[1:0] == 2'h3 |=> O_CHAN0_CAPTURE_IN == $past(I_CHAN0_CAPTURE_SRC[3]))
    else $error("channel 0 code 11 did not route pin 3");

  chk_chan0_reserved: assert property ( // RULE_01
    capture_trap_input_select[1:0] inside {2'h1, 2'h2} |=> O_CHAN0_CAPTURE_IN == INACTIVE_LEVEL)
    else $error("channel 0 reserved code not parked");

  chk_chan1_route: assert property ( // RULE_02
    1'b1 |=> O_CHAN1_CAPTURE_IN == $past(I_CHAN1_CAPTURE_SRC[capture_trap_input_select[3:2]]))
    else $error("channel 1 routed the wrong pin");

  chk_chan2_route: assert property ( // RULE_03
    capture_trap_input_select[5:4] == 2'h2 |=> O_CHAN2_CAPTURE_IN == INACTIVE_LEVEL)
    else $error("channel 2 code 10 not parked");

  chk_trap_route: assert property ( // RULE_04
    capture_trap_input_select[7:6] == 2'h2 |=> O_TRAP_IN == $past(I_TRAP_SRC[2]))
    else $error("trap code 10 did not route pin 2");

  chk_hall_reserved: assert property ( // RULE_05
    position_run_input_select[5:4] == 2'h3 |=> O_HALL_POS2_IN == INACTIVE_LEVEL)
    else $error("hall 2 reserved code not parked");

  chk_timer_a_route: assert property ( // RULE_06
    position_run_input_select[7:6] == 2'h1 |=> O_TIMER_A_HW_RUN_IN == $past(I_TIMER_A_HW_RUN_SRC[1]))
    else $error("timer A code 01 did not route pin 1");

  chk_timer_b_route: assert property ( // RULE_07
    second_timer_run_input_select == 2'h0 |=> O_TIMER_B_HW_RUN_IN == $past(I_TIMER_B_HW_RUN_SRC[0]))
    else $error("timer B code 00 did not route pin 0");

  chk_third_reg_zero: assert property ( // RULE_08
    I_RD && I_ADDR == cuis_pkg::CUIS_OFS_SECOND_TIMER_SEL |=> O_RDATA[7:2] == 6'h00)
    else $error("reserved bits of third register read nonzero");

  chk_write_readback: assert property ( // Readback of a position/run select register write on the next cycle
    I_WR && I_ADDR == cuis_pkg::CUIS_OFS_POSITION_RUN_SEL ##1 I_RD && I_ADDR == cuis_pkg::CUIS_OFS_POSITION_RUN_SEL
    |=> O_RDATA == $past(I_WDATA, 2))
    else $error("select register write not read back");

  chk_rdata_idle: assert property (
    !I_RD |=> O_RDATA == 8'h00)
    else $error("read data stood without a read");

  cov_chan0_pin3: cover property (capture_trap_input_select[1:0] == 2'h3 ##1 O_CHAN0_CAPTURE_IN);
  cov_trap_pin1: cover property (capture_trap_input_select[7:6] == 2'h1 ##1 O_TRAP_IN);
  cov_timer_b_pin2: cover property (second_timer_run_input_select == 2'h2 ##1 O_TIMER_B_HW_RUN_IN);
  cov_write_then_read: cover property (I_WR ##1 I_RD);

endmodule // cuis_top

/* verif/cuis_pin_model.sv */
// Model of the device port pins that feed the input select block
`timescale 1ns/1ns
module cuis_pin_model (
  input wire logic [35:0] i_level,
  output logic [3:0] o_chan0,
  output logic [3:0] o_chan1,
  output logic [3:0] o_chan2,
  output logic [3:0] o_trap,
  output logic [3:0] o_hall0,
  output logic [3:0] o_hall1,
  output logic [3:0] o_hall2,
  output logic [3:0] o_timer_a,
  output logic [3:0] o_timer_b
);
  // Pins are plain levels that the bench sets just after a clock edge
  assign {o_timer_b, o_timer_a, o_hall2, o_hall1, o_hall0, o_trap, o_chan2, o_chan1, o_chan0} = i_level;
endmodule // cuis_pin_model

/* verif/cuis_top_test.sv */
// Self-checking bench for the capture unit input select block
`timescale 1ns/1ns
module cuis_top_test;
  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [35:0] lvl;
  logic [3:0] src [9];
  logic [8:0] outs;
  int errors;
  int compares;
  // --------------------------------
  // Pins, design and clock
  // --------------------------------
  cuis_pin_model i_cuis_pin_model (.i_level(lvl), .o_chan0(src[0]), .o_chan1(src[1]), .o_chan2(src[2]),
    .o_trap(src[3]), .o_hall0(src[4]), .o_hall1(src[5]), .o_hall2(src[6]), .o_timer_a(src[7]), .o_timer_b(src[8]));
  cuis_top i_cuis_top (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CHAN0_CAPTURE_SRC(src[0]), .I_CHAN1_CAPTURE_SRC(src[1]), .I_CHAN2_CAPTURE_SRC(src[2]),
    .I_TRAP_SRC(src[3]), .I_HALL_POS0_SRC(src[4]), .I_HALL_POS1_SRC(src[5]), .I_HALL_POS2_SRC(src[6]),
    .I_TIMER_A_HW_RUN_SRC(src[7]), .I_TIMER_B_HW_RUN_SRC(src[8]), .O_CHAN0_CAPTURE_IN(outs[0]),
    .O_CHAN1_CAPTURE_IN(outs[1]), .O_CHAN2_CAPTURE_IN(outs[2]), .O_TRAP_IN(outs[3]), .O_HALL_POS0_IN(outs[4]),
    .O_HALL_POS1_IN(outs[5]), .O_HALL_POS2_IN(outs[6]), .O_TIMER_A_HW_RUN_IN(outs[7]),
    .O_TIMER_B_HW_RUN_IN(outs[8]));
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Put a pattern on one input's pins, the rest low; wait out the flop after the mux
  task automatic drive(input int idx, input logic [3:0] v);
    logic [35:0] tmp;
    tmp = 36'h0;
    tmp[idx*4 +: 4] = v;
    @(posedge clk);
    lvl <= tmp;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Every code of one field: readback, a lone high pin, then all other pins high
  task automatic check_field(input logic [7:0] a, input int pos, input int idx, input logic [3:0] legal);
    logic [7:0] d;
    for (int c = 0; c < 4; c++)
    begin
      bus_write(a, 8'(c) << pos);
      bus_read(a, d);
      check("readback", {1'b0, 8'(c) << pos}, {1'b0, d});
      drive(idx, 4'h1 << c);
      check("route high", {8'h00, legal[c]}, {8'h00, outs[idx]});
      drive(idx, ~(4'h1 << c));
      check("route low", 9'h000, {8'h00, outs[idx]});
    end
    bus_write(a, 8'h00);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_reset;
    logic [7:0] d;
    for (int r = 0; r < 3; r++)
    begin
      bus_read(8'(r), d);
      check("reset value", 9'h000, {1'b0, d});
    end
    drive(0, 4'h1);
    check("chan0 pin0", 9'h001, outs);
    @(posedge clk);
    lvl <= 36'h111111111;
    repeat (2) @(posedge clk);
    #1 check("pin zero routing", 9'h1FF, outs);
  endtask
  task automatic test_capture_trap;
    check_field(8'h00, 0, 0, 4'h9);
    check_field(8'h00, 2, 1, 4'hF);
    check_field(8'h00, 4, 2, 4'hB);
    check_field(8'h00, 6, 3, 4'h7);
  endtask
  task automatic test_position_run;
    check_field(8'h01, 0, 4, 4'h7);
    check_field(8'h01, 2, 5, 4'h7);
    check_field(8'h01, 4, 6, 4'h7);
    check_field(8'h01, 6, 7, 4'h7);
  endtask
  task automatic test_second_timer;
    logic [7:0] d;
    check_field(8'h02, 0, 8, 4'h7);
    bus_write(8'h02, 8'hFE);
    bus_read(8'h02, d);
    check("upper bits", 9'h002, {1'b0, d});
    bus_write(8'h02, 8'h00);
  endtask
  task automatic test_unmapped;
    logic [7:0] d;
    bus_write(8'h00, 8'h5A);
    bus_write(8'h03, 8'hFF);
    bus_read(8'h03, d);
    check("unmapped read", 9'h000, {1'b0, d});
    bus_read(8'h00, d);
    check("kept value", 9'h05A, {1'b0, d});
  endtask
  // Write and read with no gap; read data must stand one cycle only
  task automatic test_back_to_back;
    @(posedge clk);
    addr <= 8'h01;
    wdata <= 8'hA5;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("back to back read", 9'h0A5, {1'b0, rdata});
    @(posedge clk);
    #1 check("read data idle", 9'h000, {1'b0, rdata});
  endtask
  // Reset in mid-run: written fields fall back to code 00
  task automatic test_mid_reset;
    logic [7:0] d;
    @(posedge clk);
    lvl <= 36'h0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 3; r++)
    begin
      bus_read(8'(r), d);
      check("mid-run reset value", 9'h000, {1'b0, d});
    end
    @(posedge clk);
    lvl <= 36'h111111111;
    repeat (2) @(posedge clk);
    #1 check("pin zero after reset", 9'h1FF, outs);
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // --------------------------------
  // Main sequence and watchdog
  // --------------------------------
  initial
  begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    lvl = 36'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_capture_trap();
    test_position_run();
    test_second_timer();
    test_unmapped();
    test_back_to_back();
    test_mid_reset();
    print_verdict();
  end
  // Whole run needs under 3000 cycles; allow ten times that
  initial
  begin
    #300000;
    errors++;
    print_verdict();
  end
endmodule // cuis_top_test
